/* File: verilog/profiling_config_regs.sv */
// profiling_config_regs: feature configuration and control-block address registers
//
// Function
// [R1] bit 29 continuous mode, else synchronized
// [R2] bit 30 stores time stamp if available
// [R3] bit 31 gates threshold interrupt
// [R4] bits 39:32 core id into records
// [R5] bits 47:40 vector for threshold interrupt
// [R6] software loads vector when enabling interrupt
// [R7] control-block address register at C000_0106h
// [R8] address read has no side effects
// [R9] nonzero address write faults, value kept
// [R10] zero write stops profiling, drops state
// [R11] block accesses use linear address directly
// [R12] address resets to zero, profiling disabled
// [R13] configuration register resets to zero
// [R14] reserved configuration bits read zero
`timescale 1ns/1ns
module profiling_config_regs
(
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // register access
    input  wire profiling_pkg::msr_req_t    req,
    output profiling_pkg::msr_rsp_t         rsp,
    // load from the block-load instruction path
    input  wire logic                       cb_load,
    input  wire logic [63:0]                cb_load_addr,
    // profiler side
    input  wire logic                       tstamp_present,
    input  wire logic                       thresh_hit,
    output profiling_pkg::cfg_fields_t      cfg_out,
    output logic                            profiler_on,
    output logic                            continuous_mode_en,
    output logic                            tstamp_store_en,
    output logic [63:0]                     cb_linear_addr,
    output logic                            state_discard,
    output logic                            thresh_irq,
    output logic [7:0]                      thresh_irq_vector
);

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic        hit_cfg;      // access targets configuration
    logic        hit_cb;       // access targets block address
    logic [63:0] cfg;          // configuration register
    logic [63:0] cb_addr;      // block linear address
    logic        zero_write;   // stop request

    // full 32-bit compare, so neither register has an alias
    assign hit_cfg    = (req.addr == profiling_pkg::ADDR_CFG);
    // block address register sits at its fixed register address
    assign hit_cb     = (req.addr == profiling_pkg::ADDR_CB);                      // [R7]
    // a zero write is the only register write the address accepts
    assign zero_write = req.wr && hit_cb && (req.wdata == 64'h0);                 // [R10]

    ////////////////////////////////////////////////////////////////////////
    // configuration register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cfg <= profiling_pkg::CFG_RESET;                                      // [R13]
        // reserved bits masked on the way in, so reads show zero
        else if (req.wr && hit_cfg)
            cfg <= req.wdata & profiling_pkg::CFG_WR_MASK;                        // [R14]
    end

    ////////////////////////////////////////////////////////////////////////
    // control-block address register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cb_addr <= profiling_pkg::CB_RESET;                                   // [R12]
        // zero write wins over a load in the same cycle
        else if (zero_write)
            cb_addr <= 64'h0;                                                     // [R10]
        // load path hands over an address already made linear
        else if (cb_load)
            cb_addr <= cb_load_addr;                                              // [R11]
        // nonzero register writes leave the address alone  [R9]
    end

    ////////////////////////////////////////////////////////////////////////
    // discard pulse: zero write drops internal state, no flush
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state_discard <= 1'b0;
        else
            // one-cycle pulse, nothing is written back to memory
            state_discard <= zero_write;                                          // [R10]
    end

    ////////////////////////////////////////////////////////////////////////
    // register answer, registered
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp <= '0;
        end
        else
        begin
            // every access is answered on the next edge, mapped or not
            rsp.ack   <= req.rd || req.wr;
            // only the block address register refuses a write
            rsp.gp    <= req.wr && hit_cb && (req.wdata != 64'h0);                // [R9]
            // reads only return data, nothing else happens  [R8]
            if (req.rd && hit_cb)
                rsp.rdata <= cb_addr;
            else if (req.rd && hit_cfg)
                rsp.rdata <= cfg;                                                 // [R14]
            else
                // writes and unmapped reads answer zero
                rsp.rdata <= 64'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // profiler-facing fields
    // a nonzero block address means profiling runs
    assign profiler_on        = (cb_addr != 64'h0);                               // [R12]
    assign cb_linear_addr     = cb_addr;                                          // [R11]
    assign continuous_mode_en = cfg[profiling_pkg::CFG_CONTINUOUS_MODE_EN_BIT];                 // [R1]
    assign tstamp_store_en    = cfg[profiling_pkg::CFG_TSTAMP_BIT] && tstamp_present; // [R2]
    // record-writer fields from the register, time stamp enable gated by tstamp_present
    assign cfg_out.continuous = cfg[profiling_pkg::CFG_CONTINUOUS_MODE_EN_BIT];
    assign cfg_out.tstamp_en  = tstamp_store_en;
    assign cfg_out.thresh_int = cfg[profiling_pkg::CFG_INT_BIT];
    assign cfg_out.core_ident = cfg[profiling_pkg::CFG_CORE_LSB +: 8];            // [R4]
    assign cfg_out.vector     = cfg[profiling_pkg::CFG_VEC_LSB +: 8];             // [R5]

    ////////////////////////////////////////////////////////////////////////
    // threshold interrupt, one-cycle pulse with registered vector
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            thresh_irq        <= 1'b0;
            thresh_irq_vector <= 8'h00;
        end
        else
        begin
            // no interrupt while profiling is off or the enable is clear
            thresh_irq        <= thresh_hit && profiler_on && cfg[profiling_pkg::CFG_INT_BIT]; // [R3]
            // vector tracks the field, so it is valid with the pulse
            thresh_irq_vector <= cfg[profiling_pkg::CFG_VEC_LSB +: 8];            // [R5] [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // all properties sample on the core clock and sleep during reset

    // interrupt gating and vector
    chk_irq_gated: assert property (@(posedge mclk) disable iff (!rst_n)   // [R3]
        thresh_irq |-> $past(cfg[profiling_pkg::CFG_INT_BIT]) && $past(thresh_hit))
        else $error("threshold interrupt without enable");
    chk_irq_vector: assert property (@(posedge mclk) disable iff (!rst_n)  // [R5]
        thresh_irq |-> thresh_irq_vector == $past(cfg[profiling_pkg::CFG_VEC_LSB +: 8]))
        else $error("wrong interrupt vector");
    chk_irq_on: assert property (@(posedge mclk) disable iff (!rst_n)      // [R3]
        thresh_irq |-> $past(profiler_on))
        else $error("threshold interrupt while profiling off");
    chk_thresh_off: assert property (@(posedge mclk) disable iff (!rst_n)  // [R3]
        !cfg[profiling_pkg::CFG_INT_BIT] |=> !thresh_irq)
        else $error("threshold interrupt with enable clear");

    // block address register: refused writes, zero writes, clean reads
    chk_nz_fault: assert property (@(posedge mclk) disable iff (!rst_n)    // [R9]
        (req.wr && hit_cb && req.wdata != 64'h0 && !cb_load) |=> rsp.gp && $stable(cb_addr))
        else $error("nonzero write not faulted");
    chk_gp_scope: assert property (@(posedge mclk) disable iff (!rst_n)    // [R9]
        (!req.wr || !hit_cb) |=> !rsp.gp)
        else $error("fault outside block address write");
    chk_cb_hold: assert property (@(posedge mclk) disable iff (!rst_n)     // [R9]
        (!cb_load && !zero_write) |=> $stable(cb_addr))
        else $error("block address changed without cause");
    chk_zero_stop: assert property (@(posedge mclk) disable iff (!rst_n)   // [R10]
        zero_write |=> !profiler_on && state_discard)
        else $error("zero write did not stop profiling");
    chk_discard_cause: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
        state_discard |-> $past(zero_write))
        else $error("discard without zero write");
    chk_read_clean: assert property (@(posedge mclk) disable iff (!rst_n)  // [R8]
        (req.rd && !req.wr && !cb_load) |=> $stable(cb_addr) && !state_discard && rsp.ack)
        else $error("read had side effect");
    chk_cb_read: assert property (@(posedge mclk) disable iff (!rst_n)     // [R7]
        (req.rd && hit_cb) |=> rsp.rdata == $past(cb_addr))
        else $error("block address read wrong");
    chk_access_ack: assert property (@(posedge mclk) disable iff (!rst_n)  // [R7]
        (req.rd || req.wr) |=> rsp.ack)
        else $error("access not answered");

    // configuration register fields
    chk_cfg_read: assert property (@(posedge mclk) disable iff (!rst_n)    // [R14]
        (req.rd && hit_cfg) |=> rsp.rdata == $past(cfg))
        else $error("configuration read wrong");
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
        (cfg & ~profiling_pkg::CFG_WR_MASK) == 64'h0)
        else $error("reserved bits set");
    chk_core_field: assert property (@(posedge mclk) disable iff (!rst_n)  // [R4]
        (req.wr && hit_cfg) |=> cfg_out.core_ident == $past(req.wdata[profiling_pkg::CFG_CORE_LSB +: 8]))
        else $error("core id not taken");
    chk_continuous_mode_en_mode: assert property (@(posedge mclk) disable iff (!rst_n)   // [R1]
        (req.wr && hit_cfg) |=> continuous_mode_en == $past(req.wdata[profiling_pkg::CFG_CONTINUOUS_MODE_EN_BIT]))
        else $error("continuous bit wrong");
    chk_tstamp: assert property (@(posedge mclk) disable iff (!rst_n)      // [R2]
        tstamp_store_en |-> tstamp_present && cfg[profiling_pkg::CFG_TSTAMP_BIT])
        else $error("time stamp without source");

    // linear address load path
    chk_load_path: assert property (@(posedge mclk) disable iff (!rst_n)   // [R11]
        (cb_load && !zero_write) |=> cb_linear_addr == $past(cb_load_addr))
        else $error("linear address not loaded");

    // main scenarios: interrupt, refused write, stop, load, time stamp
    cov_irq:   cover property (@(posedge mclk) disable iff (!rst_n) thresh_irq);
    cov_fault: cover property (@(posedge mclk) disable iff (!rst_n) rsp.gp);
    cov_stop:  cover property (@(posedge mclk) disable iff (!rst_n) profiler_on ##1 zero_write);
    cov_load:  cover property (@(posedge mclk) disable iff (!rst_n) cb_load ##1 profiler_on);
    cov_tstamp: cover property (@(posedge mclk) disable iff (!rst_n) tstamp_store_en);

endmodule

/* File: verilog/profiling_pkg.sv */
// package: register addresses, field layout, reset values and carriers of the profiling config bank
package profiling_pkg;

    // register addresses in the model-specific register space
    localparam logic [31:0] ADDR_CB        = 32'hC0000106;     // control-block address register
    localparam logic [31:0] ADDR_CFG       = 32'hC0000105;     // feature configuration register

    // field positions of the feature configuration register
    localparam int          CFG_CONTINUOUS_MODE_EN_BIT   = 29;
    localparam int          CFG_TSTAMP_BIT = 30;
    localparam int          CFG_INT_BIT    = 31;
    localparam int          CFG_CORE_LSB   = 32;
    localparam int          CFG_VEC_LSB    = 40;

    // writable bits: lower enables 6:1 plus 31:29 and 47:32
    localparam logic [63:0] CFG_WR_MASK    = 64'h0000_FFFF_E000_007E;

    // values after reset
    localparam logic [63:0] CFG_RESET      = 64'h0000_0000_0000_0000;
    localparam logic [63:0] CB_RESET       = 64'h0000_0000_0000_0000;

    // register access request
    typedef struct packed {
        logic        rd;      // read strobe
        logic        wr;      // write strobe
        logic [31:0] addr;    // register address
        logic [63:0] wdata;   // write data
    } msr_req_t;

    // register access answer
    typedef struct packed {
        logic        ack;     // access done
        logic        gp;      // protection fault
        logic [63:0] rdata;   // read data
    } msr_rsp_t;

    // fields handed to the record writer
    typedef struct packed {
        logic [7:0]  vector;       // interrupt vector
        logic [7:0]  core_ident;   // core identifier
        logic        thresh_int;   // threshold interrupt allowed
        logic        tstamp_en;    // store time stamp
        logic        continuous;   // continuous mode
    } cfg_fields_t;

endpackage

/* File: tb/tb_profiling_config_regs.sv */
// bench for the profiling configuration and control-block address registers
`timescale 1ns/1ns
module tb_profiling_config_regs;
    // clock, reset and design-facing signals
    logic                         mclk = 1'b0;
    logic                         rst_n = 1'b0;
    profiling_pkg::msr_req_t      req = '0;
    profiling_pkg::msr_rsp_t      rsp;
    profiling_pkg::msr_rsp_t      r;
    logic                         cb_load = 1'b0;
    logic [63:0]                  cb_load_addr = 64'h0;
    logic                         tstamp_present = 1'b0;
    logic                         thresh_hit = 1'b0;
    profiling_pkg::cfg_fields_t   cfg_out;
    logic                         profiler_on;
    logic                         continuous_mode_en;
    logic                         tstamp_store_en;
    logic [63:0]                  cb_linear_addr;
    logic                         state_discard;
    logic                         thresh_irq;
    logic [7:0]                   thresh_irq_vector;
    int                           fail_count = 0;
    int                           n_tests = 0;
    localparam logic [31:0]       CB = 32'hC0000106;
    localparam logic [31:0]       CF = 32'hC0000105;
    localparam logic [63:0]       LA = 64'h0000_7FFF_1234_5640;

    profiling_config_regs i_profiling_config_regs (.mclk(mclk), .rst_n(rst_n), .req(req), .rsp(rsp),
        .cb_load(cb_load), .cb_load_addr(cb_load_addr), .tstamp_present(tstamp_present),
        .thresh_hit(thresh_hit), .cfg_out(cfg_out), .profiler_on(profiler_on),
        .continuous_mode_en(continuous_mode_en), .tstamp_store_en(tstamp_store_en),
        .cb_linear_addr(cb_linear_addr), .state_discard(state_discard), .thresh_irq(thresh_irq),
        .thresh_irq_vector(thresh_irq_vector));

    // free-running core clock
    always #25 mclk = ~mclk;

    // one compare, counted
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one register access, answer taken just after the acknowledging edge
    task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
        @(posedge mclk);
        req <= '{rd: ~w, wr: w, addr: a, wdata: d};
        @(posedge mclk);
        req.rd <= 1'b0;
        req.wr <= 1'b0;
        #1;
        r = rsp;
        chk(64'(r.ack), 64'h1);
    endtask

    // one-cycle pulse on the load or threshold inputs
    task automatic strobe(input logic ld, input logic hit);
        @(posedge mclk);
        cb_load <= ld;
        thresh_hit <= hit;
        @(posedge mclk);
        cb_load <= 1'b0;
        thresh_hit <= 1'b0;
        #1;
    endtask

    // verdict and end of run
    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog, far beyond the fewer than fifty cycles of the sequence
    initial
    begin
        #100000;
        fail_count++;
        end_of_test();
    end

    // main sequence
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        acc(0, CB, 0); chk(r.rdata, 64'h0);
        chk(64'(profiler_on), 64'h0);
        acc(0, CF, 0); chk(r.rdata, 64'h0);
        acc(1, CF, 64'h0000_0000_4000_0000);
        chk(64'(tstamp_store_en), 64'h0);
        tstamp_present <= 1'b1;
        acc(1, CF, 64'hFFFF_FFFF_FFFF_FFFF);
        acc(0, CF, 0); chk(r.rdata, 64'h0000_FFFF_E000_007E);
        chk(64'(tstamp_store_en), 64'h1);
        chk(64'(continuous_mode_en), 64'h1);
        acc(1, CF, 64'h0000_A55C_2000_0000);
        chk(64'(tstamp_store_en), 64'h0);
        chk(64'(cfg_out), 64'h0000_0000_0005_2AE1);
        // load a linear block address, then read it back
        cb_load_addr <= LA;
        strobe(1, 0); chk(64'(profiler_on), 64'h1);
        acc(0, CB, 0); chk(r.rdata, LA);
        chk(64'(state_discard), 64'h0);
        chk(cb_linear_addr, LA);
        // threshold with interrupt disabled, then enabled
        strobe(0, 1); chk(64'(thresh_irq), 64'h0);
        acc(1, CF, 64'h0000_A55C_8000_0000);
        chk(64'(continuous_mode_en), 64'h0);
        strobe(0, 1); chk(64'(thresh_irq), 64'h1);
        chk(64'(thresh_irq_vector), 64'hA5);
        // nonzero address write is refused
        acc(1, CB, 64'h1); chk(64'(r.gp), 64'h1);
        chk(cb_linear_addr, LA);
        acc(0, 32'hC0000107, 0); chk(r.rdata, 64'h0);
        chk(64'(r.gp), 64'h0);
        // zero write stops profiling at once
        acc(1, CB, 64'h0); chk(64'(state_discard), 64'h1);
        chk(64'(r.gp), 64'h0);
        chk(64'(profiler_on), 64'h0);
        acc(0, CB, 0); chk(r.rdata, 64'h0);
        // reset in mid-run clears the configuration again
        acc(1, CF, 64'h0000_A55C_2000_0000);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        chk(64'(continuous_mode_en), 64'h0);
        acc(0, CF, 0); chk(r.rdata, 64'h0);
        end_of_test();
    end
endmodule
